// file: src/pin_mux_pkg.sv
// package for the port pin function mux: register map, field layout, reset values
// assumes a 32-bit AHB-Lite slave with word-aligned registers
package pin_mux_pkg;

  localparam logic [7:0] OFS_EDGE_POLARITY    = 8'h00;
  localparam logic [7:0] OFS_CONVERTER_BYPASS = 8'h04;
  localparam logic [7:0] OFS_DIRECT_CONNECT   = 8'h08;
  localparam logic [7:0] OFS_TRIGGER_ROUTE    = 8'h0c;
  localparam logic [7:0] OFS_IRQ_ENABLE       = 8'h10;
  localparam logic [7:0] OFS_IRQ_FLAGS        = 8'h14;
  localparam logic [7:0] OFS_GPIO_OUT         = 8'h18;
  localparam logic [7:0] OFS_GPIO_DIR         = 8'h1c;
  localparam logic [7:0] OFS_GPIO_IN          = 8'h20;
  localparam logic [7:0] OFS_OPEN_DRAIN       = 8'h24;
  localparam logic [7:0] OFS_MODE_STATUS      = 8'h28;
  localparam logic [7:0] OFS_WAKEUP_ENABLE    = 8'h2c;

  localparam logic [7:0] RST_EDGE_POLARITY    = 8'h00;
  localparam logic [7:0] RST_CONVERTER_BYPASS = 8'h00;
  localparam logic [7:0] RST_DIRECT_CONNECT   = 8'h00;
  localparam logic [1:0] RST_TRIGGER_ROUTE    = 2'h0;

  // trigger route field values
  localparam logic [1:0] ROUTE_NONE    = 2'h0;
  localparam logic [1:0] ROUTE_HIGH_PIN = 2'h1;
  localparam logic [1:0] ROUTE_LOW_PIN  = 2'h2;

  // glitch filter: a level must stand this many cycles before it counts
  localparam int FILTER_NS     = 100;
  localparam int CLK_PERIOD_NS = 20;
  localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] oe;
  } pin_drive_t;

endpackage

// file: src/port_pin_function_mux.sv
// pin integration logic: per-pin function priority, debug pin mode capture,
// trigger routing, high-voltage input edge logic, converter bypass control
// assumes a single AHB-Lite master, pins synchronised here, peripherals on clk_i
`timescale 1ns/1ps

module port_pin_function_mux #(
  parameter int NUM_HVI = 2
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // debug pin (open-drain style three-signal pin)
  input  wire logic        background_debug_pin_i,
  output logic             background_debug_pin_o,
  output logic             background_debug_pin_oe_n_o,
  input  wire logic        debug_tx_i,
  input  wire logic        debug_tx_en_i,
  output logic             debug_rx_o,
  output logic             mode_select_input_o,
  // analog port, 16 pins: high byte pins 15..8, low byte 7..0
  input  wire logic [15:0] analog_port_pin_i,
  output logic      [15:0] analog_port_pin_o,
  output logic      [15:0] analog_port_pin_oe_n_o,
  input  wire logic [15:0] periph_out_i,
  input  wire logic [15:0] periph_en_i,
  output logic      [15:0] key_wakeup_o,
  output logic             conversion_trigger_input_o,
  // serial-capable ports, 8 pins
  input  wire logic [7:0]  serial_pin_i,
  output logic      [7:0]  serial_pin_o,
  output logic      [7:0]  serial_pin_oe_n_o,
  input  wire pin_mux_pkg::pin_drive_t serial_drive_i,
  // high-voltage inputs
  input  wire logic [NUM_HVI-1:0] high_voltage_input_i,
  output logic      [NUM_HVI-1:0] converter_stage_enable_o,
  output logic                    irq_o
);

  initial begin
    if (NUM_HVI < 1 || NUM_HVI > 8) begin
      $error("NUM_HVI must be 1..8");
    end
  end

  localparam int NIRQ = 16 + NUM_HVI;

  // registers
  logic [7:0]        edge_polarity;
  logic [7:0]        converter_bypass;
  logic [7:0]        direct_connect;
  logic [1:0]        trigger_route;
  logic [NIRQ-1:0]   irq_enable;
  logic [NIRQ-1:0]   irq_flags;
  logic [15:0]       wakeup_enable;
  logic [15:0]       gpio_out;
  logic [15:0]       gpio_dir;
  logic [7:0]        open_drain;
  logic              mode_select;
  logic              in_reset_window;

  // synchronisers
  logic [15:0]       ad_s1, ad_s2;
  logic [7:0]        ser_s1, ser_s2;
  logic [NUM_HVI-1:0] hv_s1, hv_s2;
  logic              dbg_s1, dbg_s2;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ad_s1  <= 16'h0000;
      ad_s2  <= 16'h0000;
      ser_s1 <= 8'h00;
      ser_s2 <= 8'h00;
      hv_s1  <= '0;
      hv_s2  <= '0;
    end else begin
      ad_s1  <= analog_port_pin_i;
      ad_s2  <= ad_s1;
      ser_s1 <= serial_pin_i;
      ser_s2 <= ser_s1;
      hv_s1  <= high_voltage_input_i;
      hv_s2  <= hv_s1;
    end
  end

  // strap sync
  // no reset here: a reset sync would hand the capture a constant, not the strap level
  always_ff @(posedge clk_i) begin
    dbg_s1 <= background_debug_pin_i;
    dbg_s2 <= dbg_s1;
  end

  // mode capture
  // the strap is caught by the first clocked edge after release, from the synced pin
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_reset_window <= 1'b1;
      mode_select     <= 1'b0;
    end else if (in_reset_window) begin
      in_reset_window <= 1'b0;
      mode_select     <= dbg_s2;
    end
  end

  // ahb-lite address phase
  logic       wr_pend;
  logic [7:0] wr_addr;
  wire        ahb_go   = hsel_i && hready_i && htrans_i == pin_mux_pkg::HTRANS_NONSEQ;
  wire        ahb_rd   = ahb_go && !hwrite_i;
  wire        wr_ep    = wr_pend && wr_addr == pin_mux_pkg::OFS_EDGE_POLARITY;
  wire        wr_bp    = wr_pend && wr_addr == pin_mux_pkg::OFS_CONVERTER_BYPASS;
  wire        wr_dc    = wr_pend && wr_addr == pin_mux_pkg::OFS_DIRECT_CONNECT;
  wire        wr_tr    = wr_pend && wr_addr == pin_mux_pkg::OFS_TRIGGER_ROUTE;
  wire        wr_ie    = wr_pend && wr_addr == pin_mux_pkg::OFS_IRQ_ENABLE;
  wire        wr_fl    = wr_pend && wr_addr == pin_mux_pkg::OFS_IRQ_FLAGS;
  wire        wr_go    = wr_pend && wr_addr == pin_mux_pkg::OFS_GPIO_OUT;
  wire        wr_gd    = wr_pend && wr_addr == pin_mux_pkg::OFS_GPIO_DIR;
  wire        wr_od    = wr_pend && wr_addr == pin_mux_pkg::OFS_OPEN_DRAIN;
  wire        wr_we    = wr_pend && wr_addr == pin_mux_pkg::OFS_WAKEUP_ENABLE;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr_i)
      pin_mux_pkg::OFS_EDGE_POLARITY:    rd_mux[7:0] = edge_polarity;
      pin_mux_pkg::OFS_CONVERTER_BYPASS: rd_mux[7:0] = converter_bypass;
      pin_mux_pkg::OFS_DIRECT_CONNECT:   rd_mux[7:0] = direct_connect;
      pin_mux_pkg::OFS_TRIGGER_ROUTE:    rd_mux[1:0] = trigger_route;
      pin_mux_pkg::OFS_IRQ_ENABLE:       rd_mux[NIRQ-1:0] = irq_enable;
      pin_mux_pkg::OFS_IRQ_FLAGS:        rd_mux[NIRQ-1:0] = irq_flags;
      pin_mux_pkg::OFS_GPIO_OUT:         rd_mux[15:0] = gpio_out;
      pin_mux_pkg::OFS_GPIO_DIR:         rd_mux[15:0] = gpio_dir;
      pin_mux_pkg::OFS_GPIO_IN:          rd_mux[23:0] = {ser_s2, ad_s2};
      pin_mux_pkg::OFS_OPEN_DRAIN:       rd_mux[7:0] = open_drain;
      pin_mux_pkg::OFS_MODE_STATUS:      rd_mux[0] = mode_select;
      pin_mux_pkg::OFS_WAKEUP_ENABLE:    rd_mux[15:0] = wakeup_enable;
      default:                           rd_mux = 32'h0000_0000;
    endcase
  end

  // zero-wait slave: read data is latched at the address phase edge
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_pend     <= 1'b0;
      wr_addr     <= 8'h00;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      wr_pend  <= ahb_go && hwrite_i;
      wr_addr  <= haddr_i;
      if (ahb_rd) begin
        hrdata_o <= rd_mux;
      end
    end
  end

  // polarity writable any time; bypass; route field
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      edge_polarity    <= pin_mux_pkg::RST_EDGE_POLARITY;
      converter_bypass <= pin_mux_pkg::RST_CONVERTER_BYPASS;
      direct_connect   <= pin_mux_pkg::RST_DIRECT_CONNECT;
      trigger_route    <= pin_mux_pkg::RST_TRIGGER_ROUTE;
      irq_enable       <= '0;
      wakeup_enable    <= 16'h0000;
      gpio_out         <= 16'h0000;
      gpio_dir         <= 16'h0000;
      open_drain       <= 8'h00;
    end else begin
      if (wr_ep) edge_polarity    <= hwdata_i[7:0];
      if (wr_bp) converter_bypass <= hwdata_i[7:0];
      if (wr_dc) direct_connect   <= hwdata_i[7:0];
      if (wr_tr) trigger_route    <= hwdata_i[1:0];
      if (wr_ie) irq_enable       <= hwdata_i[NIRQ-1:0];
      if (wr_we) wakeup_enable    <= hwdata_i[15:0];
      if (wr_go) gpio_out         <= hwdata_i[15:0];
      if (wr_gd) gpio_dir         <= hwdata_i[15:0];
      if (wr_od) open_drain       <= hwdata_i[7:0];
    end
  end

  // glitch filter per interrupt input, then edge detect
  logic [NIRQ-1:0] raw_in, filt, filt_d, edge_hit;
  assign raw_in = {hv_s2, ad_s2};

  genvar gi;
  generate
    for (gi = 0; gi < NIRQ; gi++) begin : g_filt
      logic [7:0] cnt;
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          cnt     <= 8'h00;
          filt[gi] <= 1'b0;
        end else if (raw_in[gi] == filt[gi]) begin
          cnt <= 8'h00;
        end else if (cnt == 8'(pin_mux_pkg::FILTER_CYCLES - 1)) begin
          cnt      <= 8'h00;
          filt[gi] <= raw_in[gi];
        end else begin
          cnt <= cnt + 8'h01;
        end
      end
      // rising when polarity 1, falling when 0; gpio pins use rising
      wire pol = (gi >= 16) ? edge_polarity[(gi >= 16) ? gi - 16 : 0] : 1'b1;
      assign edge_hit[gi] = pol ? (filt[gi] && !filt_d[gi]) : (!filt[gi] && filt_d[gi]);
    end
  endgenerate

  // sticky flags, set wins over write-one-to-clear
  logic [NIRQ-1:0] next_flags;
  assign next_flags = (irq_flags & ~(wr_fl ? hwdata_i[NIRQ-1:0] : '0)) | edge_hit;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      filt_d    <= '0;
      irq_flags <= '0;
      irq_o     <= 1'b0;
    end else begin
      filt_d    <= filt;
      irq_flags <= next_flags;
      irq_o     <= |(next_flags & irq_enable);
    end
  end

  // output priority per pin: peripheral function above gpio
  // open-drain mode on serial pins drives only low
  logic [15:0] next_ad_o, next_ad_oe_n;
  logic [7:0]  next_ser_o, next_ser_oe_n;
  assign next_ad_o    = (periph_en_i & periph_out_i) | (~periph_en_i & gpio_out);
  assign next_ad_oe_n = ~(periph_en_i | gpio_dir);
  assign next_ser_o   = serial_drive_i.data & ~open_drain;
  assign next_ser_oe_n = ~(serial_drive_i.oe & ~(open_drain & serial_drive_i.data));

  // trigger from whichever pin the route selects
  wire next_trig = (trigger_route == pin_mux_pkg::ROUTE_HIGH_PIN) ? ad_s2[15] :
                   (trigger_route == pin_mux_pkg::ROUTE_LOW_PIN)  ? ad_s2[1]  : 1'b0;

  // converter stage used unless bypassed under direct connect
  wire [NUM_HVI-1:0] next_stage_en = ~(converter_bypass[NUM_HVI-1:0] & direct_connect[NUM_HVI-1:0]);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      analog_port_pin_o           <= 16'h0000;
      analog_port_pin_oe_n_o      <= 16'hffff;
      serial_pin_o                <= 8'h00;
      serial_pin_oe_n_o           <= 8'hff;
      conversion_trigger_input_o  <= 1'b0;
      converter_stage_enable_o    <= '1;
      key_wakeup_o                <= 16'h0000;
      background_debug_pin_o      <= 1'b0;
      background_debug_pin_oe_n_o <= 1'b1;
      debug_rx_o                  <= 1'b1;
      mode_select_input_o         <= 1'b0;
    end else begin
      analog_port_pin_o          <= next_ad_o;
      analog_port_pin_oe_n_o     <= next_ad_oe_n;
      serial_pin_o               <= next_ser_o;
      serial_pin_oe_n_o          <= next_ser_oe_n;
      conversion_trigger_input_o <= next_trig;
      converter_stage_enable_o   <= next_stage_en;
      // key wakeup from flagged gpio pins
      key_wakeup_o               <= irq_flags[15:0] & wakeup_enable;
      // debug function owns the pin after reset, drives low only
      background_debug_pin_o      <= 1'b0;
      background_debug_pin_oe_n_o <= in_reset_window | ~(debug_tx_en_i & ~debug_tx_i);
      debug_rx_o                  <= dbg_s2;
      mode_select_input_o         <= mode_select;
    end
  end

  // assertions
  AST_STAGE_BYPASS: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (converter_bypass[0] && direct_connect[0]) |=> !converter_stage_enable_o[0])
    else $error("converter stage not bypassed");
  AST_BYPASS_IGNORED: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !direct_connect[0] |=> converter_stage_enable_o[0])
    else $error("bypass acted without direct connect");
  AST_POL_WRITE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_ep |=> edge_polarity == $past(hwdata_i[7:0]))
    else $error("polarity write lost");
  AST_FLAG_STICKY: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (irq_flags[0] && !wr_fl) |=> irq_flags[0])
    else $error("flag dropped without clear");
  AST_IRQ_RAISE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (edge_hit[16] && irq_enable[16]) |=> irq_o)
    else $error("enabled edge gave no request");
  // two-cycle high pulse on a quiet input
  sequence s_short_pulse;
    (!filt[16] && !raw_in[16]) ##1 raw_in[16] [*2] ##1 !raw_in[16];
  endsequence
  AST_GLITCH: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_short_pulse |-> !filt[16] [*6])
    else $error("glitch passed filter");
  AST_HV_POL: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (filt[16] != filt_d[16] && filt[16] == edge_polarity[0]) |=> irq_flags[16])
    else $error("wrong hvi edge");
  AST_ROUTE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    trigger_route == pin_mux_pkg::ROUTE_LOW_PIN |=> conversion_trigger_input_o == $past(ad_s2[1]))
    else $error("trigger misrouted");
  AST_PRIO: assert property (@(posedge clk_i) disable iff (!nrst_i)
    periph_en_i[0] |=> analog_port_pin_o[0] == $past(periph_out_i[0]) && !analog_port_pin_oe_n_o[0])
    else $error("priority wrong");
  AST_OD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (open_drain[0] && serial_drive_i.data[0]) |=> serial_pin_oe_n_o[0])
    else $error("open drain drove high");
  AST_MODE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !in_reset_window |=> mode_select_input_o == $past(mode_select))
    else $error("mode select unstable");

endmodule

// file: testbench/pin_board.sv
// board side of the pin mux: pulled-up debug and serial wires, driven analog pins
// assumes every pin enable from the mux is active low
`timescale 1ns/1ps
module pin_board (
  input  wire logic        dbg_o_i,
  input  wire logic        dbg_oe_n_i,
  input  wire logic        dbg_ext_low_i,
  output logic             dbg_pin_o,
  input  wire logic [15:0] ad_o_i,
  input  wire logic [15:0] ad_oe_n_i,
  input  wire logic [15:0] ad_ext_i,
  output logic      [15:0] ad_pin_o,
  input  wire logic [7:0]  ser_o_i,
  input  wire logic [7:0]  ser_oe_n_i,
  output logic      [7:0]  ser_pin_o
);
  // debug wire
  // pull-up, so a released wire reads high and never keeps an old level
  assign dbg_pin_o = ((!dbg_oe_n_i && !dbg_o_i) || dbg_ext_low_i) ? 1'b0 : 1'b1;
  assign ser_pin_o = (ser_o_i | ser_oe_n_i);
  assign ad_pin_o = (ad_o_i & ~ad_oe_n_i) | (ad_ext_i & ad_oe_n_i);
endmodule

// file: testbench/port_pin_function_mux_tb.sv
// self-checking bench for the pin mux: ahb-lite master tasks, random stimulus
// assumes the mux answers with zero wait states and registered outputs
`timescale 1ns/1ps
module port_pin_function_mux_tb;
  logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, hrdy, hresp, dbg_o, dbg_oe_n;
  logic [7:0] haddr = 8'h00, ser_o, ser_oe_n, ser_pin;
  logic [1:0] htrans = 2'h0, high_voltage_input = 2'h0, stage;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rdata, seed = 32'hc3d922e7, v, w;
  logic tx = 1'b1, tx_en = 1'b0, dbg_low = 1'b0, dbg_rx, mode, trig, irq, dbg_pin;
  logic [15:0] ad_o, ad_oe_n, ad_ext = 16'h0, ad_pin, pout = 16'h0, pen = 16'h0, kwu;
  pin_mux_pkg::pin_drive_t sdrv = '0;
  int error_cnt = 0, checks = 0;

  always #10 clk = ~clk;

  port_pin_function_mux #(.NUM_HVI(2)) dut (
    .clk_i(clk), .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
    .hresp_o(hresp), .background_debug_pin_i(dbg_pin), .background_debug_pin_o(dbg_o),
    .background_debug_pin_oe_n_o(dbg_oe_n), .debug_tx_i(tx), .debug_tx_en_i(tx_en),
    .debug_rx_o(dbg_rx), .mode_select_input_o(mode), .analog_port_pin_i(ad_pin),
    .analog_port_pin_o(ad_o), .analog_port_pin_oe_n_o(ad_oe_n), .periph_out_i(pout),
    .periph_en_i(pen), .key_wakeup_o(kwu), .conversion_trigger_input_o(trig),
    .serial_pin_i(ser_pin), .serial_pin_o(ser_o), .serial_pin_oe_n_o(ser_oe_n),
    .serial_drive_i(sdrv), .high_voltage_input_i(high_voltage_input), .converter_stage_enable_o(stage), .irq_o(irq));

  pin_board board (
    .dbg_o_i(dbg_o), .dbg_oe_n_i(dbg_oe_n), .dbg_ext_low_i(dbg_low), .dbg_pin_o(dbg_pin),
    .ad_o_i(ad_o), .ad_oe_n_i(ad_oe_n), .ad_ext_i(ad_ext), .ad_pin_o(ad_pin),
    .ser_o_i(ser_o), .ser_oe_n_i(ser_oe_n), .ser_pin_o(ser_pin));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] exp_pin(input logic [15:0] en, po, g);
    return (en & po) | (~en & g);
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one single word transfer; read data lands in rdata
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= pin_mux_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rdata = hrdata;
  endtask

  task automatic do_reset(input logic low);
    nrst <= 1'b0;
    dbg_low <= low;
    tick(10);
    check("oe_n in reset", {ad_oe_n, ser_oe_n}, 32'h00ffffff);
    check("stage in reset", stage, 2'h3);
    nrst <= 1'b1;
    tick(4);
    dbg_low <= 1'b0;
    check("mode pin", mode, low ? 32'h0 : 32'h1);
    xfer(1'b0, pin_mux_pkg::OFS_MODE_STATUS, 32'h0);
    check("mode reg", rdata[0], low ? 32'h0 : 32'h1);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    tick(20000);
    error_cnt++;
    print_verdict();
  end

  initial begin
    do_reset(1'b1);
    // reset values and an unmapped word read back zero
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, (i == 4) ? 8'h3c : 8'(i * 4), 32'h0);
      check("reset value", rdata, 32'h0);
    end
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      xfer(1'b1, pin_mux_pkg::OFS_EDGE_POLARITY, v);
      xfer(1'b0, pin_mux_pkg::OFS_EDGE_POLARITY, 32'h0);
      check("polarity rw", rdata, {24'h0, v[7:0]});
      // first pass: bypass set with direct connect clear must be ignored
      v = (i == 0) ? 32'hff : rnd();
      w = (i == 0) ? 32'h00 : rnd();
      xfer(1'b1, pin_mux_pkg::OFS_CONVERTER_BYPASS, v);
      xfer(1'b1, pin_mux_pkg::OFS_DIRECT_CONNECT, w);
      tick(4);
      check("stage", stage, 2'(~(v[1:0] & w[1:0])));
    end
    xfer(1'b1, pin_mux_pkg::OFS_GPIO_DIR, 32'hffff);
    for (int i = 0; i < 6; i++) begin
      pen <= (i == 0) ? 16'h0 : 16'(rnd());
      pout <= 16'(rnd());
      v = rnd();
      xfer(1'b1, pin_mux_pkg::OFS_GPIO_OUT, v);
      tick(4);
      check("pin out", ad_o, exp_pin(pen, pout, v[15:0]));
      check("pin oe_n", ad_oe_n, 32'h0);
    end
    pen <= 16'h0;
    xfer(1'b1, pin_mux_pkg::OFS_GPIO_DIR, 32'h0);
    for (int r = 0; r < 8; r++) begin
      xfer(1'b1, pin_mux_pkg::OFS_TRIGGER_ROUTE, r / 2);
      ad_ext <= 16'(rnd());
      tick(6);
      check("trigger", trig, (r / 2 == 1) ? ad_ext[15] : (r / 2 == 2) ? ad_ext[1] : 1'b0);
    end
    ad_ext <= 16'h0;
    xfer(1'b1, pin_mux_pkg::OFS_IRQ_ENABLE, 32'h30000);
    for (int p = 0; p < 2; p++) begin
      xfer(1'b1, pin_mux_pkg::OFS_EDGE_POLARITY, {2{p[0]}});
      high_voltage_input <= {2{~p[0]}};
      tick(12);
      xfer(1'b1, pin_mux_pkg::OFS_IRQ_FLAGS, 32'hffffffff);
      high_voltage_input <= {2{p[0]}};
      tick(2);
      high_voltage_input <= {2{~p[0]}};
      tick(12);
      xfer(1'b0, pin_mux_pkg::OFS_IRQ_FLAGS, 32'h0);
      check("glitch flags", rdata[17:16], 32'h0);
      high_voltage_input <= {2{p[0]}};
      tick(12);
      xfer(1'b0, pin_mux_pkg::OFS_IRQ_FLAGS, 32'h0);
      check("edge flags", rdata[17:16], 32'h3);
      check("irq set", irq, 32'h1);
      xfer(1'b1, pin_mux_pkg::OFS_IRQ_FLAGS, 32'h30000);
      tick(2);
      check("irq clear", irq, 32'h0);
    end
    xfer(1'b1, pin_mux_pkg::OFS_WAKEUP_ENABLE, 32'h1);
    ad_ext <= 16'h0081;
    tick(12);
    xfer(1'b0, pin_mux_pkg::OFS_IRQ_FLAGS, 32'h0);
    check("pin flags", rdata[15:0], 32'h0081);
    check("wakeup", kwu, 32'h1);
    xfer(1'b1, pin_mux_pkg::OFS_OPEN_DRAIN, 32'h0f);
    for (int i = 0; i < 4; i++) begin
      sdrv <= {8'(rnd()), 8'hff};
      tick(4);
      check("serial oe_n", ser_oe_n, sdrv.data & 8'h0f);
      check("serial wire", ser_pin, sdrv.data);
      xfer(1'b0, pin_mux_pkg::OFS_GPIO_IN, 32'h0);
      check("serial in", rdata[23:16], sdrv.data);
      check("pins in", rdata[15:0], 32'h0081);
    end
    tx_en <= 1'b1;
    tx <= 1'b0;
    tick(5);
    check("debug low", {dbg_pin, dbg_rx}, 32'h0);
    tx <= 1'b1;
    tick(5);
    check("debug high", {dbg_pin, dbg_rx}, 32'h3);
    do_reset(1'b0);
    print_verdict();
  end
endmodule
